// ---- bench/clp_clock_ctrl_asserts.sv ----
// Port assertions of the clock and low-power controller.
// Assumes one pclk domain and presetn asynchronous, active low.
`include "clp_defines.vh"

module clp_clock_ctrl_chk (
    input logic        pclk,
    input logic        presetn,
    input logic [7:0]  paddr,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [31:0] pwdata,
    input logic        bypass_input_select,
    input logic        crystal_in_pin,
    input logic        crystal_out_pin,
    input logic        crystal_out_oe_n,
    input logic        sys_clk_en,
    input logic        cpu_clk_en,
    input logic [10:0] periph_clk_en,
    input logic        wdg_clk_en,
    input logic        regulator_on,
    input logic        ram_retain,
    input logic        bor_enable,
    input logic        clock_fail_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire clr = psel && penable && pwrite && paddr == `CLP_A_FAIL
               && pwdata[`CLP_FAIL_FLAG];

    cpu_needs_sys_a: assert property (cpu_clk_en |-> sys_clk_en)
        else $error("cpu pulse without system tick");
    periph_needs_sys_a: assert property (|periph_clk_en |-> sys_clk_en)
        else $error("peripheral pulse without system tick");
    regoff_cpu_a: assert property (!regulator_on |-> !cpu_clk_en)
        else $error("cpu pulse with regulator off");
    wdg_pulse_a: assert property (wdg_clk_en |=> !wdg_clk_en [*8])
        else $error("watchdog ticks too close");
    retain_live_a: assert property
        ($past(presetn) |-> ram_retain && bor_enable)
        else $error("retention or brown-out detect dropped");
    fail_hold_a: assert property
        (clock_fail_irq && !clr && !$past(clr) |=> clock_fail_irq)
        else $error("failure request dropped without clear");
    bypass_oe_a: assert property
        (bypass_input_select |=> crystal_out_oe_n)
        else $error("crystal output driven in bypass");
    xout_inv_a: assert property
        (!crystal_out_oe_n |-> crystal_out_pin == !$past(crystal_in_pin))
        else $error("crystal output not inverse of input");

    cover property (clock_fail_irq);
    cover property (!regulator_on);
    cover property (bypass_input_select && crystal_out_oe_n);
endmodule // clp_clock_ctrl_chk

bind clp_clock_ctrl clp_clock_ctrl_chk clp_clock_ctrl_chk_inst (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .bypass_input_select, .crystal_in_pin, .crystal_out_pin,
    .crystal_out_oe_n, .sys_clk_en, .cpu_clk_en, .periph_clk_en,
    .wdg_clk_en, .regulator_on, .ram_retain, .bor_enable, .clock_fail_irq
);

// ---- bench/clp_xtal_model.sv ----
// Crystal or external clock source on the crystal input pin.
// Assumes pclk as time base; toggles every HALF pclk cycles while run.
module clp_xtal_model #(
    parameter int HALF = 5
) (
    input  logic pclk,
    input  logic run,
    output logic crystal_in_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial crystal_in_pin = 1'b0;
    // A dead crystal stands still, so the monitor sees no edge at all
    always @(posedge pclk)
    begin
        cnt <= (cnt + 1) % HALF;
        if (run && cnt == 0)
            crystal_in_pin <= ~crystal_in_pin;
    end
endmodule // clp_xtal_model

// ---- bench/tb.sv ----
// Self-checking bench of the clock and low-power controller.
// Assumes the crystal model as far side; the bench is the APB master.
`include "clp_defines.vh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] x;
        logic        e;
    } clp_row_t;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, crystal_settle_count = `CLP_SETTLE_C1;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, crystal_out_oe_n, xrun = 1'b1;
    logic        slow_osc_sysclk_allow = 1'b0, bypass_input_select = 1'b0;
    logic        wakeup_clock_src_sel = 1'b0, crystal_in_pin, crystal_out_pin;
    logic        irq_internal = 1'b0, irq_external = 1'b0, awu_irq = 1'b0;
    logic        sys_clk_en, cpu_clk_en, awu_clk_en, wdg_clk_en;
    logic        regulator_on, ram_retain, bor_enable, clock_fail_irq;
    logic [10:0] periph_clk_en, seen;
    int          n_errors = 0, checks_done = 0, ns, nc, np;
    clp_row_t    rows[10] = '{
        '{1'b0, `CLP_A_GATE1, 32'h0, 32'hFF, 1'b0},
        '{1'b0, `CLP_A_GATE2, 32'h0, 32'h8C, 1'b0},
        '{1'b0, `CLP_A_ICTRL, 32'h0, 32'h00, 1'b0},
        '{1'b0, `CLP_A_PWR, 32'h0, 32'h01, 1'b0},
        '{1'b1, `CLP_A_GATE1, 32'h55, 32'h0, 1'b0},
        '{1'b0, `CLP_A_GATE1, 32'h0, 32'h55, 1'b0},
        '{1'b1, `CLP_A_GATE2, 32'hFF, 32'h0, 1'b0},
        '{1'b0, `CLP_A_GATE2, 32'h0, 32'h8C, 1'b0},
        '{1'b1, 8'h18, 32'hFF, 32'h0, 1'b1},
        '{1'b0, 8'h18, 32'h0, 32'h00, 1'b1}};

    clp_clock_ctrl #(.WAKE_ON_CYC(8), .WAKE_OFF_CYC(16), .AWU_XTAL_DIV(4))
        clp_clock_ctrl_inst (.*);
    clp_xtal_model clp_xtal_model_inst (.pclk, .run(xrun), .crystal_in_pin);

    initial forever #4 pclk = ~pclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic poll(input logic [7:0] a, input logic [31:0] m, x);
        for (int k = 0; k < 200; k++)
        begin
            apb(1'b0, a, 32'h0);
            if ((rd & m) === x)
                break;
        end
        chk(rd & m, x);
    endtask

    task automatic cnt(input int n);
        ns = 0;
        nc = 0;
        np = 0;
        seen = 11'h000;
        repeat (n)
        begin
            @(posedge pclk);
            ns += sys_clk_en;
            nc += cpu_clk_en;
            np += |periph_clk_en;
            seen |= periph_clk_en;
        end
    endtask

    // Wake vectors are {internal, external, wakeup unit}
    task automatic lp(input logic [1:0] m, input logic [4:0] st,
                      input logic [2:0] bad, good, input logic ron);
        apb(1'b1, `CLP_A_PWR, {30'h0, m});
        @(posedge pclk);
        cnt(60);
        chk(regulator_on, ron);
        chk({nc != 0, ns != 0, np != 0}, {1'b0, m != 2'h3, m == 2'h1});
        {irq_internal, irq_external, awu_irq} <= bad;
        cnt(3);
        {irq_internal, irq_external, awu_irq} <= 3'b000;
        apb(1'b0, `CLP_A_PWR, 32'h0);
        chk(rd, {27'h0, st});
        {irq_internal, irq_external, awu_irq} <= good;
        @(posedge pclk);
        {irq_internal, irq_external, awu_irq} <= 3'b000;
        cnt(40);
        apb(1'b0, `CLP_A_PWR, 32'h0);
        chk(rd, 32'h01);
    endtask

    task automatic report_and_stop;
        $display("mismatches=%0d compares=%0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        #300000;
        n_errors++;
        report_and_stop;
    end

    initial
    begin
        repeat (4) @(posedge pclk);
        chk({ram_retain, bor_enable}, 2'h0);
        chk({regulator_on, crystal_out_oe_n}, 2'h3);
        presetn <= 1'b1;
        cnt(3);
        chk({ram_retain, bor_enable}, 2'h3);
        foreach (rows[i])
        begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk(er, rows[i].e);
            if (!rows[i].w)
                chk(rd, rows[i].x);
        end
        cnt(60);
        chk(seen, {3'h7, 8'h55});
        apb(1'b1, `CLP_A_SRC, 32'h02);
        poll(`CLP_A_SRC, 32'h13, 32'h00);
        apb(1'b1, `CLP_A_ICTRL, 32'h01);
        poll(`CLP_A_ICTRL, 32'h02, 32'h02);
        apb(1'b1, `CLP_A_SRC, 32'h01);
        poll(`CLP_A_SRC, 32'h13, 32'h01);
        apb(1'b1, `CLP_A_FAIL, 32'h01);
        xrun <= 1'b0;
        repeat (400) if (!clock_fail_irq) @(posedge pclk);
        chk(clock_fail_irq, 1'b1);
        poll(`CLP_A_SRC, 32'h03, 32'h00);
        apb(1'b0, `CLP_A_FAIL, 32'h0);
        chk(rd, 32'h09);
        cnt(50);
        chk(clock_fail_irq, 1'b1);
        apb(1'b1, `CLP_A_FAIL, 32'h08);
        cnt(3);
        chk(clock_fail_irq, 1'b0);
        apb(1'b1, `CLP_A_ICTRL, 32'h01);
        bypass_input_select <= 1'b1;
        cnt(2);
        chk(crystal_out_oe_n, 1'b1);
        lp(2'h1, 5'h02, 3'b000, 3'b100, 1'b1);
        lp(2'h2, 5'h04, 3'b100, 3'b001, 1'b1);
        apb(1'b1, `CLP_A_ICTRL, 32'h20);
        lp(2'h2, 5'h04, 3'b100, 3'b010, 1'b0);
        lp(2'h3, 5'h08, 3'b101, 3'b010, 1'b0);
        report_and_stop;
    end
endmodule // tb

// ---- rtl/clp_clock_ctrl.v ----
// Clock source selection, crystal failure fallback, peripheral clock
// gating and low-power mode sequencing, behind an APB slave.
// Assumes all inputs except the asynchronous presetn synchronous to pclk; oscillators appear as enables.
//
// Operation
// R1 - Slow RC tick runs always, free of main clock, feeds watchdog/wakeup.
// R2 - Slow RC selectable as system clock only when its option bit allows.
// R3 - Crystal selectable as main source in run mode, 1 to 24 MHz.
// R4 - Bypass mode accepts an external clock up to 24 MHz on input.
// R5 - Monitor detects crystal loss and raises a failure request.
// R6 - On crystal loss switch to fast RC divided by eight.
// R7 - First gate register: one bit per timer, serial, SPI, I2C clock.
// R8 - Second gate register: CAN bit 7, ADC bit 3, wakeup bit 2.
// R9 - Wait stops CPU clock only; any interrupt resumes.
// R10 - Active-halt stops CPU and peripherals; wakeup unit or external wakes.
// R11 - Active-halt with regulator on keeps regulator, faster wake.
// R12 - Active-halt with regulator off powers regulator down, slower wake.
// R13 - Halt stops all clocks, regulator off, wakes on external event only; wdg_clk_en keeps ticking from the slow RC.
// R14 - Low-power keeps RAM, brown-out detect, clocks only selected modules.
// R15 - Bypass option: 0 crystal on both pins, 1 external clock.
// R16 - Settle option codes E1, D2, B4, 00 give 0.5, 8, 128, 2048 cycles.
// R17 - Internal clock control bit chooses regulator off in active-halt.
// R18 - Wakeup clock option: 0 slow RC, 1 prescaled crystal.
// R19 - Gate bit 1 passes peripheral clock, 0 holds it stopped.
// R20 - Every source change, fallback included, is free of truncated pulses.
// R21 - Failure flag held until acknowledged; fallback held until reselected.
//
// The APB interface to the registers and the address map were chosen for this implementation.
`include "clp_defines.vh"

module clp_clock_ctrl #(
    parameter WAKE_ON_CYC  = `CLP_WAKE_ON_CYC,
    parameter WAKE_OFF_CYC = `CLP_WAKE_OFF_CYC,
    parameter AWU_XTAL_DIV = `CLP_AWU_XTAL_DIV
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        slow_osc_sysclk_allow,
    input  wire        bypass_input_select,
    input  wire [7:0]  crystal_settle_count,
    input  wire        wakeup_clock_src_sel,
    input  wire        crystal_in_pin,
    output reg         crystal_out_pin,
    output reg         crystal_out_oe_n,
    input  wire        irq_internal,
    input  wire        irq_external,
    input  wire        awu_irq,
    output reg         sys_clk_en,
    output reg         cpu_clk_en,
    output reg  [10:0] periph_clk_en,
    output reg         awu_clk_en,
    output reg         wdg_clk_en,
    output reg         regulator_on,
    output reg         ram_retain,
    output reg         bor_enable,
    output reg         clock_fail_irq
);

// ----------------------------------------------------------------------
// States
// ----------------------------------------------------------------------
localparam [2:0] SW_IDLE = 3'b001;
localparam [2:0] SW_OLD  = 3'b010;
localparam [2:0] SW_NEW  = 3'b100;

localparam [4:0] PM_RUN   = 5'b00001;
localparam [4:0] PM_WAIT  = 5'b00010;
localparam [4:0] PM_AHALT = 5'b00100;
localparam [4:0] PM_HALT  = 5'b01000;
localparam [4:0] PM_WAKE  = 5'b10000;

localparam [15:0] WAKE_ON  = WAKE_ON_CYC[15:0];
localparam [15:0] WAKE_OFF = WAKE_OFF_CYC[15:0];
localparam [7:0]  AWU_LAST = AWU_XTAL_DIV[7:0] - 8'h01;

// ----------------------------------------------------------------------
// Functions
// ----------------------------------------------------------------------
function src_tick;
    input [1:0] s;
    input       f;
    input       x;
    input       l;
    begin
        case (s)
            `CLP_SRC_FRC:  src_tick = f;
            `CLP_SRC_XTAL: src_tick = x;
            `CLP_SRC_SLOW: src_tick = l;
            default:       src_tick = 1'b0;
        endcase
    end
endfunction

function [11:0] settle_target;
    input [7:0] code;
    begin
        case (code)
            `CLP_SETTLE_C0: settle_target = `CLP_SETTLE_N0;
            `CLP_SETTLE_C1: settle_target = `CLP_SETTLE_N1;
            `CLP_SETTLE_C2: settle_target = `CLP_SETTLE_N2;
            default:        settle_target = `CLP_SETTLE_N3;
        endcase
    end
endfunction

// ----------------------------------------------------------------------
// Registers and state
// ----------------------------------------------------------------------
reg        xtal_en;
reg        xtal_rdy;
reg        reg_off_sel;
reg        mon_en;
reg        fail_flag;
reg [7:0]  gate1;
reg [7:0]  gate2;
reg [1:0]  act_src;
reg [1:0]  tgt_src;
reg [2:0]  sw_state;
reg [4:0]  pm_state;
reg        pm_reg_off;
reg [15:0] wake_cnt;
reg [11:0] settle_cnt;
reg        xtal_q;
reg [2:0]  fb_cnt;
reg        fb_tick;
reg [7:0]  awu_div;
reg        awu_xtick;

wire       slow_tick;
wire       frc_tick;
wire       mon_fail;
wire       xtal_tick;
wire       act_tick;
wire       awu_tick;
wire       wr;
wire       rd_setup;
wire       hit;
wire       run_like;

// ----------------------------------------------------------------------
// Oscillators
// ----------------------------------------------------------------------
clp_tick_div #(
    .DIV (`CLP_SLOW_DIV),
    .W   (10)
) u_slow_rc (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (slow_tick)
);

clp_tick_div #(
    .DIV (`CLP_FAST_DIV),
    .W   (4)
) u_fast_rc (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (frc_tick)
);

// Crystal or bypass input: one tick per rising edge, only once enabled
assign xtal_tick = crystal_in_pin & ~xtal_q & xtal_en; // R3 R4

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        xtal_q           <= 1'b0;
        crystal_out_pin  <= 1'b0;
        crystal_out_oe_n <= 1'b1;
        fb_cnt           <= 3'h0;
        fb_tick          <= 1'b0;
        awu_div          <= 8'h00;
        awu_xtick        <= 1'b0;
        wdg_clk_en       <= 1'b0;
        ram_retain       <= 1'b0;
        bor_enable       <= 1'b0;
    end
    else
    begin
        xtal_q           <= crystal_in_pin;
        // Inverting amplifier only in crystal mode; pin released in bypass
        crystal_out_pin  <= ~crystal_in_pin;
        crystal_out_oe_n <= bypass_input_select | ~xtal_en; // R15
        fb_tick          <= frc_tick && (fb_cnt == 3'h7); // R6
        if (frc_tick)
            fb_cnt <= fb_cnt + 3'h1;
        awu_xtick <= 1'b0;
        if (xtal_tick)
        begin
            if (awu_div == AWU_LAST)
            begin
                awu_div   <= 8'h00;
                awu_xtick <= 1'b1;
            end
            else
                awu_div <= awu_div + 8'h01;
        end
        wdg_clk_en <= slow_tick; // R1
        ram_retain <= 1'b1; // R14
        bor_enable <= 1'b1; // R14
    end
end

assign awu_tick = wakeup_clock_src_sel ? awu_xtick : slow_tick; // R18 R1

// ----------------------------------------------------------------------
// Crystal settle and failure monitor
// ----------------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        settle_cnt <= 12'h000;
        xtal_rdy   <= 1'b0;
    end
    else if (!xtal_en || mon_fail)
    begin
        settle_cnt <= 12'h000;
        xtal_rdy   <= 1'b0;
    end
    else if (xtal_tick && !xtal_rdy)
    begin
        // Half a cycle rounds up to the first full edge
        settle_cnt <= settle_cnt + 12'h001;
        if (settle_cnt + 12'h001 >= settle_target(crystal_settle_count))
            xtal_rdy <= 1'b1; // R16
    end
end

clp_clock_monitor #(
    .LIMIT (`CLP_MON_LIMIT),
    .W     (9)
) u_monitor (
    .pclk      (pclk),
    .presetn   (presetn),
    .enable    (mon_en & xtal_rdy),
    .xtal_tick (xtal_tick),
    .fail      (mon_fail)
);

// ----------------------------------------------------------------------
// APB slave
// ----------------------------------------------------------------------
assign wr       = psel & penable & pwrite;
assign rd_setup = psel & ~penable & ~pwrite;
assign hit      = (paddr == `CLP_A_ICTRL) || (paddr == `CLP_A_SRC) ||
                  (paddr == `CLP_A_FAIL)  || (paddr == `CLP_A_GATE1) ||
                  (paddr == `CLP_A_GATE2) || (paddr == `CLP_A_PWR);
// Zero wait states; unmapped addresses answer with an error
assign pready   = 1'b1;
assign pslverr  = psel & penable & ~hit;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        prdata <= 32'h0000_0000;
    else if (rd_setup)
    begin
        case (paddr)
            `CLP_A_ICTRL: prdata <= {26'h0, reg_off_sel, 3'h0,
                                     xtal_rdy, xtal_en};
            `CLP_A_SRC:   prdata <= {27'h0, (sw_state != SW_IDLE),
                                     2'h0, act_src};
            `CLP_A_FAIL:  prdata <= {28'h0, fail_flag, 2'h0, mon_en};
            `CLP_A_GATE1: prdata <= {24'h0, gate1};
            `CLP_A_GATE2: prdata <= {24'h0, gate2};
            `CLP_A_PWR:   prdata <= {27'h0, pm_state};
            default:      prdata <= 32'h0000_0000;
        endcase
    end
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        xtal_en     <= 1'b0;
        reg_off_sel <= 1'b0;
        mon_en      <= 1'b0;
        fail_flag   <= 1'b0;
        gate1       <= `CLP_GATE1_RST;
        gate2       <= `CLP_GATE2_RST;
    end
    else
    begin
        if (wr && paddr == `CLP_A_ICTRL)
        begin
            xtal_en     <= pwdata[`CLP_ICTRL_XEN];
            reg_off_sel <= pwdata[`CLP_ICTRL_REGOFF]; // R17
        end
        if (wr && paddr == `CLP_A_FAIL)
            mon_en <= pwdata[`CLP_FAIL_MONEN];
        if (wr && paddr == `CLP_A_GATE1)
            gate1 <= pwdata[7:0]; // R7
        if (wr && paddr == `CLP_A_GATE2)
            gate2 <= pwdata[7:0] & `CLP_GATE2_MASK; // R8
        // Detection wins over a same-cycle acknowledge
        if (mon_fail)
            fail_flag <= 1'b1; // R5 R21
        else if (wr && paddr == `CLP_A_FAIL && pwdata[`CLP_FAIL_FLAG])
            fail_flag <= 1'b0; // R21
        // Crystal drops out of service after a loss
        if (mon_fail)
            xtal_en <= 1'b0;
    end
end

// ----------------------------------------------------------------------
// Source switch
// ----------------------------------------------------------------------
// Requested switches only at tick boundaries: the old source finishes its pulse,
// then the next pulse comes whole from the new one. No partial pulses.
assign act_tick = src_tick(act_src, fb_tick, xtal_tick, slow_tick);

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        act_src  <= `CLP_SRC_FRC;
        tgt_src  <= `CLP_SRC_FRC;
        sw_state <= SW_IDLE;
    end
    else if (mon_fail)
    begin
        // Forced fallback, held until software picks a source again
        act_src  <= `CLP_SRC_FRC; // R6 R21
        tgt_src  <= `CLP_SRC_FRC;
        sw_state <= SW_IDLE; // R20
    end
    else
    begin
        if (wr && paddr == `CLP_A_SRC && sw_state == SW_IDLE)
        begin
            if (pwdata[1:0] == `CLP_SRC_FRC)
                tgt_src <= `CLP_SRC_FRC;
            else if (pwdata[1:0] == `CLP_SRC_XTAL && xtal_rdy)
                tgt_src <= `CLP_SRC_XTAL; // R3
            else if (pwdata[1:0] == `CLP_SRC_SLOW &&
                     slow_osc_sysclk_allow)
                tgt_src <= `CLP_SRC_SLOW; // R2
        end
        case (sw_state)
            SW_IDLE:
                if (tgt_src != act_src)
                    sw_state <= SW_OLD;
            SW_OLD:
                if (act_tick)
                begin
                    act_src  <= tgt_src; // R20
                    sw_state <= SW_NEW;
                end
            SW_NEW:
                if (act_tick)
                    sw_state <= SW_IDLE;
            default:
                sw_state <= SW_IDLE;
        endcase
    end
end

// ----------------------------------------------------------------------
// Low-power sequencer
// ----------------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pm_state   <= PM_RUN;
        pm_reg_off <= 1'b0;
        wake_cnt   <= 16'h0000;
    end
    else
    begin
        case (pm_state)
            PM_RUN:
                if (wr && paddr == `CLP_A_PWR)
                begin
                    if (pwdata[1:0] == `CLP_MODE_WAIT)
                        pm_state <= PM_WAIT;
                    else if (pwdata[1:0] == `CLP_MODE_AHALT)
                    begin
                        pm_state   <= PM_AHALT;
                        pm_reg_off <= reg_off_sel; // R11 R12
                    end
                    else if (pwdata[1:0] == `CLP_MODE_HALT)
                    begin
                        pm_state   <= PM_HALT;
                        pm_reg_off <= 1'b1; // R13
                    end
                end
            PM_WAIT:
                if (irq_internal || irq_external || awu_irq)
                    pm_state <= PM_RUN; // R9
            PM_AHALT:
                if (awu_irq || irq_external)
                begin
                    pm_state <= PM_WAKE; // R10
                    wake_cnt <= pm_reg_off ? WAKE_OFF : WAKE_ON; // R11 R12
                end
            PM_HALT:
                if (irq_external)
                begin
                    pm_state <= PM_WAKE; // R13
                    wake_cnt <= WAKE_OFF;
                end
            PM_WAKE:
                if (wake_cnt <= 16'h0001)
                begin
                    pm_state   <= PM_RUN;
                    pm_reg_off <= 1'b0;
                    wake_cnt   <= 16'h0000;
                end
                else
                    wake_cnt <= wake_cnt - 16'h0001;
            default:
                pm_state <= PM_RUN;
        endcase
    end
end

// ----------------------------------------------------------------------
// Clock enables out
// ----------------------------------------------------------------------
assign run_like = (pm_state == PM_RUN) || (pm_state == PM_WAIT);

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        sys_clk_en     <= 1'b0;
        cpu_clk_en     <= 1'b0;
        periph_clk_en  <= 11'h000;
        awu_clk_en     <= 1'b0;
        regulator_on   <= 1'b1;
        clock_fail_irq <= 1'b0;
    end
    else
    begin
        sys_clk_en     <= act_tick & (pm_state != PM_HALT); // R20 R13
        cpu_clk_en     <= act_tick & (pm_state == PM_RUN); // R9 R10
        // Peripherals see only their own gated ticks
        periph_clk_en  <= {gate2[`CLP_GATE2_AWU], gate2[`CLP_GATE2_ADC],
                           gate2[`CLP_GATE2_CAN], gate1}
                          & {11{act_tick & run_like}}; // R19 R14
        awu_clk_en     <= awu_tick & gate2[`CLP_GATE2_AWU] &
                          (run_like || pm_state == PM_AHALT); // R10
        regulator_on   <= ~(pm_reg_off && (pm_state == PM_AHALT ||
                            pm_state == PM_HALT)); // R12 R13
        clock_fail_irq <= fail_flag | mon_fail; // R5
    end
end

endmodule // clp_clock_ctrl

// ---- rtl/clp_clock_monitor.v ----
// Crystal loss detector: flags a failure when no crystal edge is seen
// for LIMIT pclk cycles while enabled. Pulses fail once per loss.
module clp_clock_monitor #(
    parameter LIMIT = 250,
    parameter W     = 9
) (
    input  wire pclk,
    input  wire presetn,
    input  wire enable,
    input  wire xtal_tick,
    output reg  fail
);

localparam [W-1:0] LIM = LIMIT[W-1:0];

reg [W-1:0] idle;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        idle <= {W{1'b0}};
        fail <= 1'b0;
    end
    else if (!enable || xtal_tick)
    begin
        idle <= {W{1'b0}};
        fail <= 1'b0;
    end
    else
    begin
        // Saturate so one loss gives exactly one pulse
        if (idle != LIM)
            idle <= idle + {{(W-1){1'b0}}, 1'b1};
        fail <= (idle == LIM - {{(W-1){1'b0}}, 1'b1});
    end
end

endmodule // clp_clock_monitor

// ---- rtl/clp_defines.vh ----
// Constants of the clock and low-power controller: register offsets,
// field positions, reset values, option codes and timing counts.
// Assumes a 125 MHz pclk and byte addresses on an 8-bit APB paddr.
`ifndef CLP_DEFINES_VH
`define CLP_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define CLP_A_ICTRL        8'h00
`define CLP_A_SRC          8'h04
`define CLP_A_FAIL         8'h08
`define CLP_A_GATE1        8'h0C
`define CLP_A_GATE2        8'h10
`define CLP_A_PWR          8'h14

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define CLP_ICTRL_XEN      0
`define CLP_ICTRL_XRDY     1
`define CLP_ICTRL_REGOFF   5
`define CLP_SRC_BUSY       4
`define CLP_FAIL_MONEN     0
`define CLP_FAIL_FLAG      3
`define CLP_GATE1_RST      8'hFF
`define CLP_GATE2_RST      8'h8C
`define CLP_GATE2_MASK     8'h8C
`define CLP_GATE2_CAN      7
`define CLP_GATE2_ADC      3
`define CLP_GATE2_AWU      2

// Clock source codes
`define CLP_SRC_FRC        2'h0
`define CLP_SRC_XTAL       2'h1
`define CLP_SRC_SLOW       2'h2

// Low-power mode request codes
`define CLP_MODE_WAIT      2'h1
`define CLP_MODE_AHALT     2'h2
`define CLP_MODE_HALT      2'h3

// Crystal settle option codes and counts in crystal cycles
`define CLP_SETTLE_C0      8'hE1
`define CLP_SETTLE_C1      8'hD2
`define CLP_SETTLE_C2      8'hB4
`define CLP_SETTLE_N0      12'h001
`define CLP_SETTLE_N1      12'h008
`define CLP_SETTLE_N2      12'h080
`define CLP_SETTLE_N3      12'h800

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLP_CLK_KHZ        125000
`define CLP_CLK_MHZ        125
`define CLP_SLOW_RC_KHZ    128
`define CLP_FAST_RC_KHZ    16000
`define CLP_XTAL_MIN_KHZ   1000
`define CLP_FALLBACK_DIV   8
`define CLP_AWU_XTAL_DIV   125
`define CLP_SLOW_DIV       (`CLP_CLK_KHZ / `CLP_SLOW_RC_KHZ)
`define CLP_FAST_DIV       (`CLP_CLK_KHZ / `CLP_FAST_RC_KHZ)
`define CLP_MON_LIMIT      (2 * `CLP_CLK_KHZ / `CLP_XTAL_MIN_KHZ)
`define CLP_WAKE_ON_NS     10000
`define CLP_WAKE_OFF_NS    50000
`define CLP_WAKE_ON_CYC    ((`CLP_WAKE_ON_NS * `CLP_CLK_MHZ + 999) / 1000)
`define CLP_WAKE_OFF_CYC   ((`CLP_WAKE_OFF_NS * `CLP_CLK_MHZ + 999) / 1000)

`endif

// ---- rtl/clp_tick_div.v ----
// Divider that turns pclk into a one-cycle enable pulse every DIV cycles.
// Stands in for an on-chip RC oscillator in this single-clock design.
module clp_tick_div #(
    parameter DIV = 976,
    parameter W   = 10
) (
    input  wire pclk,
    input  wire presetn,
    output reg  tick
);

localparam [W-1:0] LAST = DIV[W-1:0] - {{(W-1){1'b0}}, 1'b1};

reg [W-1:0] cnt;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        cnt  <= {W{1'b0}};
        tick <= 1'b0;
    end
    else if (cnt == LAST)
    begin
        cnt  <= {W{1'b0}};
        tick <= 1'b1;
    end
    else
    begin
        cnt  <= cnt + {{(W-1){1'b0}}, 1'b1};
        tick <= 1'b0;
    end
end

endmodule // clp_tick_div
